//--- logic/sbalu_core.sv
// How it works
// [RULE1] Sixteen-bit add, subtract, shift and logic.
// [RULE2] Arithmetic uses two's-complement representation.
// [RULE3] Update carry, zero, negative, overflow, nibble flags.
// [RULE4] Subtraction carry and nibble carry mean borrow; the code sets them to 1 when no borrow occurs.
// [RULE5] Byte or word width per instruction.
// [RULE6] Operand from register array or memory.
// [RULE7] Result goes to register array or memory.
// [RULE8] Division support for a sixteen-bit divisor.
// [RULE9] Multiplier operands are seventeen bits wide.
// [RULE10] Signed-signed and unsigned-unsigned word multiply.
// [RULE11] Unsigned by signed word multiply.
// [RULE12] Signed word times unsigned five-bit literal.
// [RULE13] Unsigned word times unsigned five-bit literal.
// [RULE14] Unsigned byte by byte multiply.
// [RULE15] Full-width products, nothing truncated.
// [RULE16] Byte flags from low byte; upper byte kept for non-multiply results written to a register. A byte-mode divide still writes the whole quotient.
`timescale 1ns/1ns
`include "sbalu_consts.svh"
module sbalu_core
#(
    parameter int WordW = `SBALU_WORD_W
)
(
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire logic                   start,
    input  wire sbalu_pkg::sbalu_op_e   op,
    input  wire logic                   byteMode,
    input  wire logic                   srcIsMem,
    input  wire logic                   dstIsMem,
    input  wire logic [WordW-1:0]       regOperandA,
    input  wire logic [WordW-1:0]       regOperandB,
    input  wire logic [WordW-1:0]       memOperandB,
    input  wire logic [WordW-1:0]       regDestOld,
    input  wire logic [4:0]             literal,
    output logic [WordW-1:0]            result_q,
    output logic [WordW-1:0]            resultHigh_q,
    output logic                        regWrite_q,
    output logic                        memWrite_q,
    output logic                        done_q,
    output logic                        busy_q,
    output logic                        divByZero_q,
    output logic [4:0]                  aluStatus_q
);
    // Operand B source is picked here; the decoder keeps the mux select stable with start.
    logic [WordW-1:0] opB;
    assign opB = srcIsMem ? memOperandB : regOperandB; // [RULE6]

    function automatic logic [33:0] mul17(input logic [16:0] a, input logic [16:0] b);
        mul17 = 34'($signed(a) * $signed(b)); // [RULE9]
    endfunction

    // Combinational datapath for single-cycle operations.
    logic [WordW-1:0]  aluRes;
    logic [WordW-1:0]  mulHigh;
    logic              cOut;
    logic              dcOut;
    logic              ovOut;
    logic              flagsArith;
    logic [16:0]       sumW;
    logic [8:0]        sumB;
    logic [4:0]        sumN;
    logic [33:0]       prod;
    logic [16:0]       ma;
    logic [16:0]       mb;
    logic              subtract;
    logic [WordW-1:0]  bEff;
    always_comb
    begin
        subtract = (op == sbalu_pkg::SBALU_SUB);
        bEff = subtract ? ~opB : opB; // [RULE2]
        sumW = 17'(regOperandA) + 17'(bEff) + 17'(subtract);
        sumB = 9'(regOperandA[7:0]) + 9'(bEff[7:0]) + 9'(subtract);
        sumN = 5'(regOperandA[3:0]) + 5'(bEff[3:0]) + 5'(subtract);
        ma = {1'b0, regOperandA};
        mb = {1'b0, opB};
        aluRes = '0;
        mulHigh = '0;
        cOut = 1'b0;
        dcOut = sumN[4]; // [RULE4]
        ovOut = 1'b0;
        flagsArith = 1'b0;
        prod = '0;
        case (op)
            sbalu_pkg::SBALU_ADD, sbalu_pkg::SBALU_SUB:
            begin
                flagsArith = 1'b1;
                if (byteMode) // [RULE5]
                begin
                    aluRes = {8'h00, sumB[7:0]};
                    cOut = sumB[8]; // [RULE4]
                    ovOut = (regOperandA[7] == bEff[7]) && (sumB[7] != regOperandA[7]);
                end
                else
                begin
                    aluRes = sumW[15:0]; // [RULE1]
                    cOut = sumW[16];
                    ovOut = (regOperandA[15] == bEff[15]) && (sumW[15] != regOperandA[15]);
                end
            end
            sbalu_pkg::SBALU_AND: aluRes = regOperandA & opB;
            sbalu_pkg::SBALU_IOR: aluRes = regOperandA | opB;
            sbalu_pkg::SBALU_XOR: aluRes = regOperandA ^ opB;
            sbalu_pkg::SBALU_SHL:
            begin
                aluRes = {regOperandA[14:0], 1'b0};
                cOut = byteMode ? regOperandA[7] : regOperandA[15];
            end
            sbalu_pkg::SBALU_LSR:
            begin
                aluRes = byteMode ? {9'h000, regOperandA[7:1]} : {1'b0, regOperandA[15:1]};
                cOut = regOperandA[0];
            end
            sbalu_pkg::SBALU_ASR:
            begin
                aluRes = byteMode ? {8'h00, regOperandA[7], regOperandA[7:1]}
                                  : {regOperandA[15], regOperandA[15:1]};
                cOut = regOperandA[0];
            end
            sbalu_pkg::SBALU_MUL_SS:
                prod = mul17({regOperandA[15], regOperandA}, {opB[15], opB}); // [RULE10]
            sbalu_pkg::SBALU_MUL_UU:
                prod = mul17(ma, mb); // [RULE10]
            sbalu_pkg::SBALU_MUL_US:
                prod = mul17(ma, {opB[15], opB}); // [RULE11]
            sbalu_pkg::SBALU_MUL_SL:
                prod = mul17({regOperandA[15], regOperandA}, {12'h000, literal}); // [RULE12]
            sbalu_pkg::SBALU_MUL_UL:
                prod = mul17(ma, {12'h000, literal}); // [RULE13]
            sbalu_pkg::SBALU_MUL_BB:
                prod = mul17({9'h000, regOperandA[7:0]}, {9'h000, opB[7:0]}); // [RULE14]
            sbalu_pkg::SBALU_PASS: aluRes = opB;
            default: aluRes = '0;
        endcase
        if (op inside {sbalu_pkg::SBALU_MUL_SS, sbalu_pkg::SBALU_MUL_UU,
                       sbalu_pkg::SBALU_MUL_US, sbalu_pkg::SBALU_MUL_SL,
                       sbalu_pkg::SBALU_MUL_UL, sbalu_pkg::SBALU_MUL_BB})
        begin
            aluRes = prod[15:0]; // [RULE15]
            mulHigh = (op == sbalu_pkg::SBALU_MUL_BB) ? 16'h0000 : prod[31:16];
        end
    end

    // Division runs one restoring step per cycle, so it takes sixteen cycles plus one.
    sbalu_pkg::sbalu_state_e state_q;
    logic [4:0]        divCount_q;
    logic [WordW-1:0]  quot_q;
    logic [WordW:0]    rem_q;
    logic [WordW-1:0]  divisor_q;
    logic              divDst_q;
    logic [WordW:0]    remShift;
    logic [WordW:0]    remTrial;
    assign remShift = {rem_q[WordW-1:0], quot_q[WordW-1]};
    assign remTrial = remShift - {1'b0, divisor_q};

    logic isMul;
    assign isMul = op inside {sbalu_pkg::SBALU_MUL_SS, sbalu_pkg::SBALU_MUL_UU,
                              sbalu_pkg::SBALU_MUL_US, sbalu_pkg::SBALU_MUL_SL,
                              sbalu_pkg::SBALU_MUL_UL, sbalu_pkg::SBALU_MUL_BB};

    // Byte results keep the old upper byte only when written back to a register.
    logic [WordW-1:0] mergedRes;
    assign mergedRes = (byteMode && !isMul && !dstIsMem)
                       ? {regDestOld[15:8], aluRes[7:0]} : aluRes; // [RULE16]

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= sbalu_pkg::SBALU_IDLE;
            divCount_q <= 5'h00;
            quot_q <= '0;
            rem_q <= '0;
            divisor_q <= '0;
            divDst_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                sbalu_pkg::SBALU_IDLE:
                    if (start && op == sbalu_pkg::SBALU_DIV_U && opB != '0)
                    begin
                        state_q <= sbalu_pkg::SBALU_DIVIDE; // [RULE8]
                        quot_q <= regOperandA;
                        rem_q <= '0;
                        divisor_q <= opB;
                        divDst_q <= dstIsMem;
                        divCount_q <= `SBALU_DIV_STEPS;
                        busy_q <= 1'b1;
                    end
                sbalu_pkg::SBALU_DIVIDE:
                begin
                    if (remTrial[WordW])
                    begin
                        rem_q <= remShift;
                        quot_q <= {quot_q[WordW-2:0], 1'b0};
                    end
                    else
                    begin
                        rem_q <= remTrial;
                        quot_q <= {quot_q[WordW-2:0], 1'b1};
                    end
                    divCount_q <= divCount_q - 5'h01;
                    if (divCount_q == 5'h01)
                        state_q <= sbalu_pkg::SBALU_DONE;
                end
                sbalu_pkg::SBALU_DONE:
                begin
                    state_q <= sbalu_pkg::SBALU_IDLE;
                    busy_q <= 1'b0;
                end
                default: state_q <= sbalu_pkg::SBALU_IDLE;
            endcase
        end
    end

    // Result and write strobes.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            result_q <= '0;
            resultHigh_q <= '0;
            regWrite_q <= 1'b0;
            memWrite_q <= 1'b0;
            done_q <= 1'b0;
            divByZero_q <= 1'b0;
        end
        else
        begin
            regWrite_q <= 1'b0;
            memWrite_q <= 1'b0;
            done_q <= 1'b0;
            divByZero_q <= 1'b0;
            if (state_q == sbalu_pkg::SBALU_DONE)
            begin
                result_q <= quot_q;
                resultHigh_q <= rem_q[WordW-1:0];
                regWrite_q <= !divDst_q; // [RULE7]
                memWrite_q <= divDst_q;
                done_q <= 1'b1;
            end
            else if (start && state_q == sbalu_pkg::SBALU_IDLE)
            begin
                if (op == sbalu_pkg::SBALU_DIV_U)
                begin
                    if (opB == '0)
                    begin
                        divByZero_q <= 1'b1;
                        done_q <= 1'b1;
                    end
                end
                else
                begin
                    result_q <= mergedRes;
                    resultHigh_q <= mulHigh;
                    regWrite_q <= !dstIsMem; // [RULE7]
                    memWrite_q <= dstIsMem;
                    done_q <= 1'b1;
                end
            end
        end
    end

    // Flags: logic and shifts touch Z and N (and C for shifts); add/sub touch all five.
    logic zeroRes;
    logic negRes;
    assign zeroRes = byteMode ? (aluRes[7:0] == 8'h00) : (aluRes == '0); // [RULE16]
    assign negRes = byteMode ? aluRes[7] : aluRes[15];
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            aluStatus_q <= `SBALU_FLAGS_RESET;
        else if (start && state_q == sbalu_pkg::SBALU_IDLE && !isMul
                 && op != sbalu_pkg::SBALU_DIV_U && op != sbalu_pkg::SBALU_PASS)
        begin
            aluStatus_q[`SBALU_FLAG_Z] <= zeroRes; // [RULE3]
            aluStatus_q[`SBALU_FLAG_N] <= negRes;
            if (flagsArith || op inside {sbalu_pkg::SBALU_SHL, sbalu_pkg::SBALU_LSR,
                                         sbalu_pkg::SBALU_ASR})
                aluStatus_q[`SBALU_FLAG_C] <= cOut;
            if (flagsArith)
            begin
                aluStatus_q[`SBALU_FLAG_OV] <= ovOut;
                aluStatus_q[`SBALU_FLAG_DC] <= dcOut;
            end
        end
    end
endmodule

//--- logic/sbalu_consts.svh
`ifndef SBALU_CONSTS_SVH
`define SBALU_CONSTS_SVH
`define SBALU_WORD_W 16
`define SBALU_BYTE_W 8
`define SBALU_MUL_W 17
`define SBALU_LIT_W 5
`define SBALU_FLAG_C 0
`define SBALU_FLAG_Z 1
`define SBALU_FLAG_N 2
`define SBALU_FLAG_OV 3
`define SBALU_FLAG_DC 4
`define SBALU_FLAGS_RESET 5'h00
`define SBALU_DIV_STEPS 5'h10
`endif

//--- logic/sbalu_pkg.sv
package sbalu_pkg;
    typedef enum logic [4:0] {
        SBALU_ADD,
        SBALU_SUB,
        SBALU_AND,
        SBALU_IOR,
        SBALU_XOR,
        SBALU_SHL,
        SBALU_LSR,
        SBALU_ASR,
        SBALU_MUL_SS,
        SBALU_MUL_UU,
        SBALU_MUL_US,
        SBALU_MUL_SL,
        SBALU_MUL_UL,
        SBALU_MUL_BB,
        SBALU_DIV_U,
        SBALU_PASS
    } sbalu_op_e;
    typedef enum logic [1:0] {
        SBALU_IDLE,
        SBALU_DIVIDE,
        SBALU_DONE
    } sbalu_state_e;
endpackage

//--- testbench/sbalu_checker.sv
`timescale 1ns/1ns
module sbalu_checker
(
    input logic                 clk,
    input logic                 rstn,
    input logic                 start,
    input sbalu_pkg::sbalu_op_e op,
    input logic                 byteMode,
    input logic                 srcIsMem,
    input logic                 dstIsMem,
    input logic [15:0]          regOperandA,
    input logic [15:0]          regOperandB,
    input logic [15:0]          regDestOld,
    input logic [15:0]          result_q,
    input logic [15:0]          resultHigh_q,
    input logic                 regWrite_q,
    input logic                 memWrite_q,
    input logic                 done_q,
    input logic                 busy_q,
    input logic                 divByZero_q,
    input logic [4:0]           aluStatus_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire take = start && !busy_q;
    wire word = take && !byteMode && !srcIsMem;
    sequence s_divTake;
        word && op == sbalu_pkg::SBALU_DIV_U && regOperandB != 16'h0000;
    endsequence
    sequence s_divRun;
        busy_q ##17 (done_q && !busy_q);
    endsequence
    a_div_span: assert property (s_divTake |=> s_divRun)
        else $error("divide timing wrong");
    a_zero_nowrite: assert property (
        divByZero_q |-> done_q && !regWrite_q && !memWrite_q)
        else $error("divide by zero wrote");
    a_single_done: assert property (take && op != sbalu_pkg::SBALU_DIV_U |=> done_q)
        else $error("done missing");
    a_add_word: assert property (word && op == sbalu_pkg::SBALU_ADD
        |=> result_q == $past(regOperandA) + $past(regOperandB))
        else $error("sum wrong");
    a_sub_borrow: assert property (word && op == sbalu_pkg::SBALU_SUB
        |=> aluStatus_q[0] == ($past(regOperandA) >= $past(regOperandB)))
        else $error("borrow wrong");
    a_zero_flag: assert property (take && !byteMode && op == sbalu_pkg::SBALU_XOR
        |=> aluStatus_q[1] == (result_q == 16'h0000))
        else $error("zero flag wrong");
    a_write_route: assert property (take && op != sbalu_pkg::SBALU_DIV_U
        |=> memWrite_q == $past(dstIsMem) && regWrite_q != memWrite_q)
        else $error("write route wrong");
    a_byte_upper: assert property (
        take && byteMode && !dstIsMem && op == sbalu_pkg::SBALU_ADD
        |=> (result_q >> 8) == ($past(regDestOld) >> 8))
        else $error("upper byte changed");
    a_mul_full: assert property (word && op == sbalu_pkg::SBALU_MUL_UU
        |=> {resultHigh_q, result_q} == $past(regOperandA) * $past(regOperandB))
        else $error("product wrong");
    a_mul_flags: assert property (take && op >= sbalu_pkg::SBALU_MUL_SS
        && op <= sbalu_pkg::SBALU_MUL_BB |=> $stable(aluStatus_q))
        else $error("multiply touched flags");
endmodule

//--- testbench/sbalu_regfile_model.sv
`timescale 1ns/1ns
module sbalu_regfile_model
(
    input logic         clk,
    input logic         rstn,
    input logic         loadEn,
    input logic [47:0]  loadData,
    input logic         regWrite,
    input logic [15:0]  wrData,
    output logic [15:0] regA,
    output logic [15:0] regB,
    output logic [15:0] regDest
);
    // Slots A and B feed operands, the third slot is the destination register.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            {regA, regB, regDest} <= 48'h0;
        else if (loadEn)
            {regA, regB, regDest} <= loadData;
        else if (regWrite)
            regDest <= wrData;
    end
endmodule

//--- testbench/sbalu_core_tb_top.sv
`timescale 1ns/1ns
module sbalu_core_tb_top;
    logic                 clk, rstn, start, byteMode, srcIsMem, dstIsMem, loadEn;
    logic                 regWr, memWr, done, busy, dz;
    sbalu_pkg::sbalu_op_e op;
    logic [15:0]          regA, regB, regDest, memB, res, resHi;
    logic [47:0]          loadData;
    logic [4:0]           literal, status;
    int                   err_count, checks, cyc;

    sbalu_regfile_model reg_u (.clk(clk), .rstn(rstn), .loadEn(loadEn), .loadData(loadData),
        .regWrite(regWr), .wrData(res), .regA(regA), .regB(regB), .regDest(regDest));
    sbalu_core dut_u (.clk(clk), .rstn(rstn), .start(start), .op(op), .byteMode(byteMode),
        .srcIsMem(srcIsMem), .dstIsMem(dstIsMem), .regOperandA(regA), .regOperandB(regB),
        .memOperandB(memB), .regDestOld(regDest), .literal(literal), .result_q(res),
        .resultHigh_q(resHi), .regWrite_q(regWr), .memWrite_q(memWr), .done_q(done),
        .busy_q(busy), .divByZero_q(dz), .aluStatus_q(status));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Loading the registers first also keeps a start out of the cycle after a divide.
    task automatic run(input int o, input logic [2:0] mode, input logic [47:0] r,
                       input logic [15:0] m);
        loadData = r;
        loadEn = 1'b1;
        @(posedge clk);
        #1;
        loadEn = 1'b0;
        {byteMode, srcIsMem, dstIsMem} = mode;
        op = sbalu_pkg::sbalu_op_e'(o);
        memB = m;
        start = 1'b1;
        @(posedge clk);
        #1;
        start = 1'b0;
        cyc = 0;
        while (done !== 1'b1 && cyc < 40)
        begin
            @(posedge clk);
            #1;
            cyc++;
        end
        chk(done, 1'b1);
    endtask

    task automatic t_arith();
        run(sbalu_pkg::SBALU_ADD, 3'b000, {16'h7fff, 16'h0001, 16'h0000}, 16'h0000);
        chk({res, 11'h0, status}, {16'h8000, 16'h001c});
        @(posedge clk);
        #1;
        chk(regDest, 16'h8000);
        run(sbalu_pkg::SBALU_ADD, 3'b000, {16'hffff, 16'h0001, 16'h0000}, 16'h0000);
        chk({res, 11'h0, status}, {16'h0000, 16'h0013});
        run(sbalu_pkg::SBALU_SUB, 3'b011, {16'h0000, 16'h5555, 16'h0000}, 16'h0001);
        chk({res, 9'h0, memWr, regWr, status}, {16'hffff, 16'h0044});
        run(sbalu_pkg::SBALU_SUB, 3'b000, {16'h0005, 16'h0003, 16'h0000}, 16'h0000);
        chk({res, 11'h0, status}, {16'h0002, 16'h0011});
        run(sbalu_pkg::SBALU_ADD, 3'b100, {16'h12ff, 16'h0001, 16'habcd}, 16'h0000);
        chk({res, 11'h0, status}, {16'hab00, 16'h0013});
        run(sbalu_pkg::SBALU_PASS, 3'b010, {16'h1111, 16'h2222, 16'h3333}, 16'h2468);
        chk({res, 11'h0, status}, {16'h2468, 16'h0013});
    endtask

    task automatic t_logic();
        logic [15:0] exp[6] = '{16'h0001, 16'h80f1, 16'h80f0, 16'h0002, 16'h4000, 16'hc000};
        logic [1:0]  nz[6] = '{2'b00, 2'b10, 2'b10, 2'b00, 2'b00, 2'b10};
        for (int i = 0; i < 6; i++)
        begin
            run(sbalu_pkg::SBALU_AND + i, 3'b000, {16'h8001, 16'h00f1, 16'h0000}, 16'h0000);
            chk({res, 14'h0, status[2:1]}, {exp[i], 14'h0, nz[i]});
        end
    endtask

    task automatic t_mul();
        logic [31:0] exp[6] = '{32'h00000006, 32'hfffb0006, 32'hfffd0006,
                                32'hffffffc2, 32'h001effc2, 32'h0000fb06};
        logic [4:0]  s;
        literal = 5'h1f;
        for (int i = 0; i < 6; i++)
        begin
            s = status;
            run(sbalu_pkg::SBALU_MUL_SS + i, 3'b000, {16'hfffe, 16'hfffd, 16'h0000}, 16'h0000);
            chk(resHi, exp[i][31:16]);
            chk(res, exp[i][15:0]);
            chk(status, s);
        end
    endtask

    task automatic t_div();
        run(sbalu_pkg::SBALU_DIV_U, 3'b000, {16'h1234, 16'h0007, 16'h0000}, 16'h0000);
        chk({resHi, res}, 32'h00050299);
        chk(cyc, 17);
        run(sbalu_pkg::SBALU_DIV_U, 3'b000, {16'h1234, 16'h0000, 16'h0000}, 16'h0000);
        chk({dz, memWr, regWr}, 3'b100);
    endtask

    task automatic test_done();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        {rstn, start, loadEn, byteMode, srcIsMem, dstIsMem} = 6'h00;
        op = sbalu_pkg::SBALU_PASS;
        {loadData, memB, literal} = 69'h0;
        err_count = 0;
        checks = 0;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        chk({resHi, res}, 32'h0);
        chk(status, 32'h0);
        t_arith();
        t_logic();
        t_mul();
        t_div();
        test_done();
    end

    initial
    begin
        #20000;
        err_count++;
        test_done();
    end
endmodule

bind sbalu_core sbalu_checker chk_u (.clk(clk), .rstn(rstn), .start(start), .op(op),
    .byteMode(byteMode), .srcIsMem(srcIsMem), .dstIsMem(dstIsMem), .regOperandA(regOperandA),
    .regOperandB(regOperandB), .regDestOld(regDestOld), .result_q(result_q),
    .resultHigh_q(resultHigh_q), .regWrite_q(regWrite_q), .memWrite_q(memWrite_q),
    .done_q(done_q), .busy_q(busy_q), .divByZero_q(divByZero_q), .aluStatus_q(aluStatus_q));
